/* bench/rfpsr_host_model.sv */
// Host side of the reply byte stream: a sink that takes the text replies.
// Assumes a single clock; the bench clears rx before each query.
`timescale 1ns/10ps
`default_nettype none
module rfpsr_host_model (
	input  wire logic       i_clock,
	input  wire logic       i_stall,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_byte,
	output logic            o_tx_ready
);
	string      rx;
	logic [1:0] ph;
	initial begin
		rx = "";
		ph = 2'h0;
		o_tx_ready = 1'b1;
	end
	// When stalling, ready is given one cycle in four so bytes must stand.
	always @(negedge i_clock) begin
		ph <= ph + 2'h1;
		o_tx_ready <= !i_stall || ph == 2'h3;
	end
	always @(posedge i_clock) begin
		if (i_tx_valid && o_tx_ready) begin
			rx = {rx, $sformatf("%c", i_tx_byte)};
		end
	end
endmodule
`default_nettype wire

/* bench/tb_rf_presence_status_reporter.sv */
// Self-checking bench of the RF presence status reporter.
// Assumes the host model sink and a millisecond shortened to five cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_rf_presence_status_reporter;
	// ****************************************
	// Stimulus signals and design
	// ****************************************
	localparam int MSC = 5;
	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   we = 1'b0;
	rfpsr_pkg::rfpsr_cfg_t  cfg = rfpsr_pkg::CFG_DEFAULT;
	logic                   basic = 1'b1;
	logic                   host_on = 1'b0;
	logic                   pres = 1'b0;
	logic                   tag = 1'b0;
	logic                   zone = 1'b0;
	logic                   first = 1'b0;
	logic                   qv = 1'b0;
	rfpsr_pkg::rfpsr_query_t qq = rfpsr_pkg::Q_RF;
	logic                   stall = 1'b0;
	logic                   rdy;
	logic                   txv;
	logic [7:0]             txb;
	logic                   txr;
	rfpsr_pkg::rfpsr_cfg_t  ocfg;
	logic                   rf_on;
	logic [7:0]             hold_s;
	logic                   no_tag;
	logic                   resend;
	int                     checks = 0;
	int                     mismatches = 0;
	int                     cyc = 0;

	always #10 clk = ~clk;

	rfpsr_top #(.MS_CYCLES_P(MSC)) u_dut (
		.i_clock(clk), .i_sys_rst(rst), .i_cfg_we(we), .i_cfg(cfg), .i_basic_proto(basic),
		.i_host_rf_on(host_on), .i_presence_sensor_input(pres), .i_tag_valid(tag),
		.i_tag_in_zone(zone), .i_first_read_mode(first), .i_query_valid(qv), .i_query(qq),
		.o_query_ready(rdy), .o_tx_valid(txv), .o_tx_byte(txb), .i_tx_ready(txr), .o_cfg(ocfg),
		.o_rf_on(rf_on), .o_unique_hold_s(hold_s), .o_no_tag_report(no_tag), .o_wiegand_resend(resend)
	);

	rfpsr_host_model u_host (
		.i_clock(clk), .i_stall(stall), .i_tx_valid(txv), .i_tx_byte(txb), .o_tx_ready(txr)
	);

	// ****************************************
	// Compare, drive and closing tasks
	// ****************************************
	task automatic report_and_stop;
		if (mismatches == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 45000) begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic cmp_str(input string nm, input string e, input string g);
		checks++;
		if (e != g) begin
			mismatches++;
			$display("[ERR] %s expected %s seen %s", nm, e, g);
		end
	endtask

	task automatic cmp_val(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmp_cfg(input string nm, input rfpsr_pkg::rfpsr_cfg_t e, input rfpsr_pkg::rfpsr_cfg_t g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Turns a reply tag constant into text, skipping the unused high bytes.
	function automatic string tg(input logic [31:0] v);
		string s;
		s = "";
		for (int i = 3; i >= 0; i--) begin
			if (v[i*8 +: 8] != 8'h00) begin
				s = {s, string'(v[i*8 +: 8])};
			end
		end
		return s;
	endfunction

	// Issues one query and waits, bounded, until the whole reply has been taken.
	task automatic ask(input rfpsr_pkg::rfpsr_query_t q, input string e);
		int n;
		n = 0;
		u_host.rx = "";
		qv = 1'b1;
		qq = q;
		@(negedge clk);
		qv = 1'b0;
		while (rdy !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		cmp_str(q.name(), e, u_host.rx);
	endtask

	task automatic wr(input rfpsr_pkg::rfpsr_cfg_t c);
		cfg = c;
		we = 1'b1;
		@(negedge clk);
		we = 1'b0;
		@(negedge clk);
	endtask

	// Counts cycles from the present pulse, or from now, to the next resend pulse.
	task automatic gap(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (resend !== 1'b1 && n < 20000);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_defaults;
		cmp_val("hold_s", 8'h78, hold_s);
		ask(rfpsr_pkg::Q_RF, {tg(rfpsr_pkg::RF_STATUS_REPLY_TAG), " C1 O0 T1 Fxx R1F G1F A09 I09\r\n"});
		ask(rfpsr_pkg::Q_PRES, {tg(rfpsr_pkg::PRESENCE_STATUS_REPLY_TAG), " P0 D0 A2 TF I0\r\n"});
		ask(rfpsr_pkg::Q_FILT, {tg(rfpsr_pkg::ID_FILTER_STATUS_REPLY_TAG), " U0 V0\r\n"});
		ask(rfpsr_pkg::Q_WMODE, {tg(rfpsr_pkg::WIEGAND_MODE_REPLY_TAG), " 0\r\n"});
		ask(rfpsr_pkg::Q_WINT, {tg(rfpsr_pkg::WIEGAND_INTERVAL_REPLY_TAG), " 01\r\n"});
		ask(rfpsr_pkg::Q_TRANS, {tg(rfpsr_pkg::TRANSLATION_REPLY_TAG), " 0\r\n"});
		ask(rfpsr_pkg::Q_ECHO, "ECHO 1\r\n");
	endtask

	task automatic t_setall;
		rfpsr_pkg::rfpsr_cfg_t c;
		rfpsr_pkg::rfpsr_cfg_t b;
		c = '{1'b0, 2'h3, 5'h00, 5'h1f, 4'hf, 4'hf, 1'b1, rfpsr_pkg::ALG_TAG, 4'he, 1'b1, 3'h4, 2'h3, 1'b1,
			8'hff, 1'b1, 1'b0};
		host_on = 1'b1;
		stall = 1'b1;
		wr(c);
		cmp_cfg("cfg_all", c, ocfg);
		cmp_val("hold_30", 8'h1e, hold_s);
		ask(rfpsr_pkg::Q_RF, {tg(rfpsr_pkg::RF_STATUS_REPLY_TAG), " C0 O1 T3 Fxx R00 G1F A0F I0F\r\n"});
		ask(rfpsr_pkg::Q_PRES, {tg(rfpsr_pkg::PRESENCE_STATUS_REPLY_TAG), " P1 D0 A1 TE I1\r\n"});
		ask(rfpsr_pkg::Q_FILT, {tg(rfpsr_pkg::ID_FILTER_STATUS_REPLY_TAG), " U4 V3\r\n"});
		ask(rfpsr_pkg::Q_WMODE, {tg(rfpsr_pkg::WIEGAND_MODE_REPLY_TAG), " 1\r\n"});
		ask(rfpsr_pkg::Q_WINT, {tg(rfpsr_pkg::WIEGAND_INTERVAL_REPLY_TAG), " FF\r\n"});
		ask(rfpsr_pkg::Q_TRANS, {tg(rfpsr_pkg::TRANSLATION_REPLY_TAG), " 1\r\n"});
		ask(rfpsr_pkg::Q_ECHO, "ECHO 0\r\n");
		stall = 1'b0;
		host_on = 1'b0;
		@(negedge clk);
		cmp_val("host_off", 8'h0, {7'h0, rf_on});
		b = c;
		b.atten = 4'h8;
		wr(b);
		cmp_cfg("cfg_bad_atten", c, ocfg);
		b = c;
		b.unique_to = rfpsr_pkg::UTO_15S;
		b.echo = 1'b1;
		basic = 1'b0;
		wr(b);
		basic = 1'b1;
		cmp_val("echo_locked", 8'h0, {7'h0, ocfg.echo});
		cmp_val("hold_15", 8'h0f, hold_s);
	endtask

	task automatic t_rf;
		rfpsr_pkg::rfpsr_cfg_t c;
		int n;
		c = rfpsr_pkg::CFG_DEFAULT;
		c.pwt_report = 1'b1;
		wr(c);
		pres = 1'b1;
		@(negedge clk);
		cmp_val("rf_rise", 8'h1, {7'h0, rf_on});
		repeat (30) @(negedge clk);
		cmp_val("rf_hold", 8'h1, {7'h0, rf_on});
		pres = 1'b0;
		@(negedge clk);
		cmp_val("rf_fall", 8'h0, {7'h0, rf_on});
		cmp_val("no_tag_pulse", 8'h1, {7'h0, no_tag});
		pres = 1'b1;
		@(negedge clk);
		tag = 1'b1;
		@(negedge clk);
		tag = 1'b0;
		pres = 1'b0;
		@(negedge clk);
		cmp_val("no_tag_quiet", 8'h0, {7'h0, no_tag});
		c.rf_off_alg = rfpsr_pkg::ALG_TAG;
		wr(c);
		pres = 1'b1;
		@(negedge clk);
		tag = 1'b1;
		@(negedge clk);
		tag = 1'b0;
		cmp_val("rf_tag_off", 8'h0, {7'h0, rf_on});
		c.rf_off_alg = rfpsr_pkg::ALG_TIMEOUT;
		c.rf_timeout = 4'h1;
		c.invert = 1'b1;
		wr(c);
		pres = 1'b0;
		@(negedge clk);
		cmp_val("rf_inv_rise", 8'h1, {7'h0, rf_on});
		pres = 1'b1;
		n = 1;
		while (rf_on === 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		cmp_val("rf_4ms", 8'h1, {7'h0, n >= 18 && n <= 23});
	endtask

	task automatic t_wiegand;
		rfpsr_pkg::rfpsr_cfg_t c;
		int n;
		c = rfpsr_pkg::CFG_DEFAULT;
		c.wiegand_en = 1'b1;
		wr(c);
		zone = 1'b1;
		gap(n);
		gap(n);
		cmp_val("resend_1s", 8'h1, {7'h0, n >= 1000 * MSC - 5 && n <= 1000 * MSC + 5});
		first = 1'b1;
		gap(n);
		cmp_val("resend_2s", 8'h1, {7'h0, n >= 2000 * MSC - 5 && n <= 2000 * MSC + 5});
		zone = 1'b0;
		first = 1'b0;
	endtask

	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_defaults();
		t_setall();
		t_rf();
		t_wiegand();
		report_and_stop();
	end
endmodule
`default_nettype wire

/* hw/rfpsr_pkg.sv */
// Constants, settings layout and reply formats of the RF presence status reporter.
// Assumes a single 50 MHz clock shared by every user of this package.
`default_nettype none
package rfpsr_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEC_MS        = 1000;
	localparam logic [3:0] TMO_INFINITE = 4'hf;
	// ****************************************
	// Reply text
	// ****************************************
	localparam int BUF_BYTES = 36;
	localparam logic [31:0] RF_STATUS_REPLY_TAG        = 32'h52465354;
	localparam logic [31:0] PRESENCE_STATUS_REPLY_TAG  = 32'h50525354;
	localparam logic [31:0] ID_FILTER_STATUS_REPLY_TAG = 32'h52463053;
	localparam logic [23:0] WIEGAND_MODE_REPLY_TAG     = 24'h544f46;
	localparam logic [23:0] WIEGAND_INTERVAL_REPLY_TAG = 24'h575449;
	localparam logic [15:0] TRANSLATION_REPLY_TAG      = 16'h5454;
	localparam logic [31:0] ECHO_REPLY_TAG             = 32'h4543484f;
	localparam logic [7:0]  CH_SP = 8'h20;
	localparam logic [7:0]  CH_CR = 8'h0d;
	localparam logic [7:0]  CH_LF = 8'h0a;
	// ****************************************
	// Setting limits and reset values
	// ****************************************
	localparam logic [3:0] ATTEN_MAX_PWR   = 4'h9;
	localparam logic [2:0] UNIQ_PASS_ALL   = 3'h4;
	localparam logic [1:0] ALG_TIMEOUT     = 2'h0;
	localparam logic [1:0] ALG_TAG         = 2'h1;
	localparam logic [1:0] ALG_PRES_FALSE  = 2'h2;
	localparam logic [1:0] UTO_2MIN        = 2'h1;
	localparam logic [1:0] UTO_15S         = 2'h2;
	localparam logic [7:0] UTO_2MIN_S      = 8'h78;
	localparam logic [7:0] UTO_15S_S       = 8'h0f;
	localparam logic [7:0] UTO_30S_S       = 8'h1e;
	localparam logic [4:0] DEF_RANGE       = 5'h1f;
	localparam logic [7:0] DEF_WIEGAND_INT = 8'h01;

	typedef struct packed {
		logic       rf_by_presence;
		logic [1:0] unique_to;
		logic [4:0] range_a;
		logic [4:0] range_g;
		logic [3:0] atten;
		logic [3:0] atten_toll;
		logic       pwt_report;
		logic [1:0] rf_off_alg;
		logic [3:0] rf_timeout;
		logic       invert;
		logic [2:0] uniq_filter;
		logic [1:0] valid_crit;
		logic       wiegand_en;
		logic [7:0] wiegand_int;
		logic       translate;
		logic       echo;
	} rfpsr_cfg_t;

	localparam rfpsr_cfg_t CFG_DEFAULT = '{
		rf_by_presence: 1'b1, unique_to: UTO_2MIN, range_a: DEF_RANGE,
		range_g: DEF_RANGE, atten: ATTEN_MAX_PWR, atten_toll: ATTEN_MAX_PWR,
		pwt_report: 1'b0, rf_off_alg: ALG_PRES_FALSE, rf_timeout: TMO_INFINITE,
		invert: 1'b0, uniq_filter: 3'h0, valid_crit: 2'h0, wiegand_en: 1'b0,
		wiegand_int: DEF_WIEGAND_INT, translate: 1'b0, echo: 1'b1};

	typedef enum logic [6:0] {
		Q_RF    = 7'h01,
		Q_PRES  = 7'h02,
		Q_FILT  = 7'h04,
		Q_WMODE = 7'h08,
		Q_WINT  = 7'h10,
		Q_TRANS = 7'h20,
		Q_ECHO  = 7'h40
	} rfpsr_query_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'h1,
		S_SEND = 2'h2
	} rfpsr_state_t;
endpackage
`default_nettype wire

/* hw/rfpsr_top.sv */
// Status query responder and RF presence control of a tag reader.
// Assumes all inputs synchronous to i_clock; replies leave as bytes ending in CR LF.
`timescale 1ns/10ps
`default_nettype none
module rfpsr_top #(
	parameter int MS_CYCLES_P = rfpsr_pkg::MS_CYCLES
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_sys_rst,
	input  wire logic                   i_cfg_we,
	input  wire rfpsr_pkg::rfpsr_cfg_t  i_cfg,
	input  wire logic                   i_basic_proto,
	input  wire logic                   i_host_rf_on,
	input  wire logic                   i_presence_sensor_input,
	input  wire logic                   i_tag_valid,
	input  wire logic                   i_tag_in_zone,
	input  wire logic                   i_first_read_mode,
	input  wire logic                   i_query_valid,
	input  wire rfpsr_pkg::rfpsr_query_t i_query,
	output logic                        o_query_ready,
	output logic                        o_tx_valid,
	output logic [7:0]                  o_tx_byte,
	input  wire logic                   i_tx_ready,
	output rfpsr_pkg::rfpsr_cfg_t       o_cfg,
	output logic                        o_rf_on,
	output logic [7:0]                  o_unique_hold_s,
	output logic                        o_no_tag_report,
	output logic                        o_wiegand_resend
);
	localparam int BW = rfpsr_pkg::BUF_BYTES * 8;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [7:0] hexc(input logic [3:0] v);
		hexc = (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
	endfunction

	function automatic logic [9:0] tmo_ms(input logic [3:0] c);
		case (c)
			4'h0: tmo_ms = 10'h000;
			4'h1: tmo_ms = 10'h004;
			4'h2: tmo_ms = 10'h008;
			4'h3: tmo_ms = 10'h00c;
			4'h4: tmo_ms = 10'h014;
			4'h5: tmo_ms = 10'h018;
			4'h6: tmo_ms = 10'h020;
			4'h7: tmo_ms = 10'h030;
			4'h8: tmo_ms = 10'h03c;
			4'h9: tmo_ms = 10'h05c;
			4'ha: tmo_ms = 10'h098;
			4'hb: tmo_ms = 10'h12c;
			4'hc: tmo_ms = 10'h1c4;
			4'hd: tmo_ms = 10'h258;
			4'he: tmo_ms = 10'h2f0;
			default: tmo_ms = 10'h3ff;
		endcase
	endfunction

	function automatic logic cfg_legal(input rfpsr_pkg::rfpsr_cfg_t c);
		cfg_legal = (c.unique_to != 2'h0) && (c.atten >= rfpsr_pkg::ATTEN_MAX_PWR) &&
			(c.atten_toll >= rfpsr_pkg::ATTEN_MAX_PWR) && (c.rf_off_alg != 2'h3) &&
			(c.uniq_filter <= rfpsr_pkg::UNIQ_PASS_ALL) && (c.wiegand_int != 8'h00);
	endfunction

	// ****************************************
	// Settings
	// ****************************************
	rfpsr_pkg::rfpsr_cfg_t cfg_r;
	rfpsr_pkg::rfpsr_cfg_t cfg_nxt;

	always_comb begin
		cfg_nxt = i_cfg;
		if (!i_basic_proto) begin
			cfg_nxt.echo = cfg_r.echo;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cfg_r <= rfpsr_pkg::CFG_DEFAULT;
		end else if (i_cfg_we && cfg_legal(i_cfg)) begin
			cfg_r <= cfg_nxt;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_unique_hold_s <= rfpsr_pkg::UTO_2MIN_S;
		end else begin
			case (cfg_r.unique_to)
				rfpsr_pkg::UTO_2MIN: o_unique_hold_s <= rfpsr_pkg::UTO_2MIN_S;
				rfpsr_pkg::UTO_15S:  o_unique_hold_s <= rfpsr_pkg::UTO_15S_S;
				default:             o_unique_hold_s <= rfpsr_pkg::UTO_30S_S;
			endcase
		end
	end

	assign o_cfg = cfg_r;

	// ****************************************
	// Millisecond and second enables
	// ****************************************
	logic [15:0] ms_cnt_r;
	logic [9:0]  sec_cnt_r;
	logic        ms_tick;
	logic        sec_tick;

	assign ms_tick  = (ms_cnt_r == 16'(MS_CYCLES_P - 1));
	assign sec_tick = ms_tick && (sec_cnt_r == 10'(rfpsr_pkg::SEC_MS - 1));

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ms_cnt_r  <= 16'h0000;
			sec_cnt_r <= 10'h000;
		end else begin
			ms_cnt_r <= ms_tick ? 16'h0000 : ms_cnt_r + 16'h0001;
			if (sec_tick) begin
				sec_cnt_r <= 10'h000;
			end else if (ms_tick) begin
				sec_cnt_r <= sec_cnt_r + 10'h001;
			end
		end
	end

	// ****************************************
	// RF control
	// ****************************************
	logic       pres;
	logic       pres_d_r;
	logic       rise;
	logic       fall;
	logic [9:0] rf_ms_r;
	logic       expired;
	logic       got_tag_r;

	assign pres    = i_presence_sensor_input ^ cfg_r.invert;
	assign rise    = pres && !pres_d_r;
	assign fall    = !pres && pres_d_r;
	assign expired = (cfg_r.rf_timeout != rfpsr_pkg::TMO_INFINITE) &&
		(rf_ms_r >= tmo_ms(cfg_r.rf_timeout));

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pres_d_r <= 1'b0;
		end else begin
			pres_d_r <= pres;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rf_ms_r <= 10'h000;
		end else if (rise) begin
			rf_ms_r <= 10'h000;
		end else if (ms_tick && o_rf_on && rf_ms_r != 10'h3ff) begin
			rf_ms_r <= rf_ms_r + 10'h001;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rf_on <= 1'b0;
		end else if (!cfg_r.rf_by_presence) begin
			o_rf_on <= i_host_rf_on;
		end else if (rise) begin
			o_rf_on <= 1'b1;
		end else if (o_rf_on) begin
			case (cfg_r.rf_off_alg)
				rfpsr_pkg::ALG_TIMEOUT:    o_rf_on <= !expired;
				rfpsr_pkg::ALG_TAG:        o_rf_on <= !(expired || i_tag_valid);
				rfpsr_pkg::ALG_PRES_FALSE: o_rf_on <= !(expired || !pres);
				default:                   o_rf_on <= 1'b0;
			endcase
		end
	end

	// A tag in the same cycle as the presence edge still counts.
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			got_tag_r       <= 1'b0;
			o_no_tag_report <= 1'b0;
		end else begin
			if (i_tag_valid) begin
				got_tag_r <= 1'b1;
			end else if (rise) begin
				got_tag_r <= 1'b0;
			end
			o_no_tag_report <= fall && cfg_r.pwt_report && !got_tag_r && !i_tag_valid;
		end
	end

	// ****************************************
	// Wiegand retransmit
	// ****************************************
	logic       zone_d_r;
	logic [8:0] w_sec_r;
	logic [8:0] w_limit;

	assign w_limit = i_first_read_mode ? {cfg_r.wiegand_int, 1'b0} : {1'b0, cfg_r.wiegand_int};

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			zone_d_r         <= 1'b0;
			w_sec_r          <= 9'h000;
			o_wiegand_resend <= 1'b0;
		end else begin
			zone_d_r         <= i_tag_in_zone;
			o_wiegand_resend <= 1'b0;
			if (!i_tag_in_zone || !zone_d_r) begin
				w_sec_r <= 9'h000;
			end else if (sec_tick && cfg_r.wiegand_en) begin
				if (w_sec_r + 9'h001 >= w_limit) begin
					w_sec_r          <= 9'h000;
					o_wiegand_resend <= 1'b1;
				end else begin
					w_sec_r <= w_sec_r + 9'h001;
				end
			end
		end
	end

	// ****************************************
	// Reply composer
	// ****************************************
	rfpsr_pkg::rfpsr_state_t state_r;
	logic [BW-1:0] buf_r;
	logic [BW-1:0] text;
	logic [5:0]    cnt_r;
	logic [5:0]    len;
	logic          take;
	logic          sent;

	assign o_query_ready = (state_r == rfpsr_pkg::S_IDLE);
	assign take          = o_query_ready && i_query_valid;
	assign o_tx_valid    = (state_r == rfpsr_pkg::S_SEND);
	assign sent          = o_tx_valid && i_tx_ready;
	assign o_tx_byte     = buf_r[BW-1 -: 8];

	// Fields are left justified in the buffer and shifted out high byte first.
	always_comb begin
		text = '0;
		len  = 6'h00;
		case (i_query)
			rfpsr_pkg::Q_RF: begin
				text = BW'({rfpsr_pkg::RF_STATUS_REPLY_TAG,
					rfpsr_pkg::CH_SP, 8'h43, hexc({3'h0, cfg_r.rf_by_presence}),
					rfpsr_pkg::CH_SP, 8'h4f, hexc({3'h0, o_rf_on}),
					rfpsr_pkg::CH_SP, 8'h54, hexc({2'h0, cfg_r.unique_to}),
					rfpsr_pkg::CH_SP, 8'h46, 8'h78, 8'h78,
					rfpsr_pkg::CH_SP, 8'h52, hexc({3'h0, cfg_r.range_a[4]}), hexc(cfg_r.range_a[3:0]),
					rfpsr_pkg::CH_SP, 8'h47, hexc({3'h0, cfg_r.range_g[4]}), hexc(cfg_r.range_g[3:0]),
					rfpsr_pkg::CH_SP, 8'h41, hexc(4'h0), hexc(cfg_r.atten),
					rfpsr_pkg::CH_SP, 8'h49, hexc(4'h0), hexc(cfg_r.atten_toll),
					rfpsr_pkg::CH_CR, rfpsr_pkg::CH_LF});
				len = 6'h23;
			end
			rfpsr_pkg::Q_PRES: begin
				text = BW'({rfpsr_pkg::PRESENCE_STATUS_REPLY_TAG,
					rfpsr_pkg::CH_SP, 8'h50, hexc({3'h0, cfg_r.pwt_report}),
					rfpsr_pkg::CH_SP, 8'h44, hexc(4'h0),
					rfpsr_pkg::CH_SP, 8'h41, hexc({2'h0, cfg_r.rf_off_alg}),
					rfpsr_pkg::CH_SP, 8'h54, hexc(cfg_r.rf_timeout),
					rfpsr_pkg::CH_SP, 8'h49, hexc({3'h0, cfg_r.invert}),
					rfpsr_pkg::CH_CR, rfpsr_pkg::CH_LF});
				len = 6'h15;
			end
			rfpsr_pkg::Q_FILT: begin
				text = BW'({rfpsr_pkg::ID_FILTER_STATUS_REPLY_TAG,
					rfpsr_pkg::CH_SP, 8'h55, hexc({1'h0, cfg_r.uniq_filter}),
					rfpsr_pkg::CH_SP, 8'h56, hexc({2'h0, cfg_r.valid_crit}),
					rfpsr_pkg::CH_CR, rfpsr_pkg::CH_LF});
				len = 6'h0c;
			end
			rfpsr_pkg::Q_WMODE: begin
				text = BW'({rfpsr_pkg::WIEGAND_MODE_REPLY_TAG, rfpsr_pkg::CH_SP,
					hexc({3'h0, cfg_r.wiegand_en}), rfpsr_pkg::CH_CR, rfpsr_pkg::CH_LF});
				len = 6'h07;
			end
			rfpsr_pkg::Q_WINT: begin
				text = BW'({rfpsr_pkg::WIEGAND_INTERVAL_REPLY_TAG, rfpsr_pkg::CH_SP,
					hexc(cfg_r.wiegand_int[7:4]), hexc(cfg_r.wiegand_int[3:0]),
					rfpsr_pkg::CH_CR, rfpsr_pkg::CH_LF});
				len = 6'h08;
			end
			rfpsr_pkg::Q_TRANS: begin
				text = BW'({rfpsr_pkg::TRANSLATION_REPLY_TAG, rfpsr_pkg::CH_SP,
					hexc({3'h0, cfg_r.translate}), rfpsr_pkg::CH_CR, rfpsr_pkg::CH_LF});
				len = 6'h06;
			end
			rfpsr_pkg::Q_ECHO: begin
				text = BW'({rfpsr_pkg::ECHO_REPLY_TAG, rfpsr_pkg::CH_SP,
					hexc({3'h0, cfg_r.echo}), rfpsr_pkg::CH_CR, rfpsr_pkg::CH_LF});
				len = 6'h08;
			end
			default: begin
				text = '0;
				len  = 6'h00;
			end
		endcase
		text = text << ((rfpsr_pkg::BUF_BYTES - int'(len)) * 8);
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r <= rfpsr_pkg::S_IDLE;
			buf_r   <= '0;
			cnt_r   <= 6'h00;
		end else begin
			case (state_r)
				rfpsr_pkg::S_IDLE: begin
					if (take && len != 6'h00) begin
						buf_r   <= text;
						cnt_r   <= len;
						state_r <= rfpsr_pkg::S_SEND;
					end
				end
				rfpsr_pkg::S_SEND: begin
					if (sent) begin
						buf_r <= {buf_r[BW-9:0], 8'h00};
						cnt_r <= cnt_r - 6'h01;
						if (cnt_r == 6'h01) begin
							state_r <= rfpsr_pkg::S_IDLE;
						end
					end
				end
				default: state_r <= rfpsr_pkg::S_IDLE;
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	sequence rf_query_s;
		take && i_query == rfpsr_pkg::Q_RF;
	endsequence
	sequence pres_query_s;
		take && i_query == rfpsr_pkg::Q_PRES;
	endsequence

	reply_start_a: assert property (rf_query_s |=> o_tx_valid && o_tx_byte == 8'h52)
		else $error("RF reply did not start");
	src_field_a: assert property (rf_query_s |=> buf_r[247:232] == {8'h43, $past(hexc({3'h0, cfg_r.rf_by_presence}))})
		else $error("RF source field wrong");
	uniq_hold_a: assert property (cfg_r.unique_to == rfpsr_pkg::UTO_15S && $stable(cfg_r) |=> o_unique_hold_s == 8'h0f)
		else $error("Uniqueness hold wrong");
	atten_floor_a: assert property (o_cfg.atten >= 4'h9 && o_cfg.atten_toll >= 4'h9)
		else $error("Attenuation below limit");
	no_tag_rpt_a: assert property (o_no_tag_report |-> $past(cfg_r.pwt_report) && !pres_d_r)
		else $error("Unexpected no-tag report");
	alg_pres_off_a: assert property (o_rf_on && cfg_r.rf_by_presence && cfg_r.rf_off_alg == 2'h2 && !pres && !rise && !i_cfg_we |=> !o_rf_on)
		else $error("RF stayed on after presence fell");
	tmo_zero_a: assert property (o_rf_on && cfg_r.rf_by_presence && cfg_r.rf_timeout == 4'h0 && !rise && !i_cfg_we |=> !o_rf_on)
		else $error("Zero timeout did not expire");
	fixed_period_a: assert property (pres_query_s |=> buf_r[231:208] == 24'h204430)
		else $error("Presence period field wrong");
	resend_cause_a: assert property (o_wiegand_resend |-> $past(i_tag_in_zone && cfg_r.wiegand_en && sec_tick))
		else $error("Wiegand resend without cause");
	echo_hold_a: assert property (!i_basic_proto && i_cfg_we |=> $stable(cfg_r.echo))
		else $error("Echo changed outside basic protocol");
endmodule
`default_nettype wire
